// ===== rtl/p1bc_defines.svh
// constants for the port 1 transceiver basic control register bank
// assumes a 32-bit axi4-lite slave, one aligned word per register
`ifndef P1BC_DEFINES_SVH
`define P1BC_DEFINES_SVH
`define P1BC_OFS_BASIC 12'h000
`define P1BC_OFS_ALT 12'h004
`define P1BC_BIT_LOOPBACK 14
`define P1BC_BIT_FORCE100 13
`define P1BC_BIT_ANEN 12
`define P1BC_BIT_PWRDN 11
`define P1BC_BIT_ANRESTART 9
`define P1BC_BIT_FULLDUP 8
`define P1BC_BIT_XALG 5
`define P1BC_BIT_FORCEMDIX 4
`define P1BC_BIT_DISMDIX 3
`define P1BC_BIT_DISFEF 2
`define P1BC_BIT_DISTX 1
`define P1BC_BIT_DISLED 0
`define P1BC_ALT_LOOPBACK 8
`define P1BC_ALT_FORCE100 6
`define P1BC_ALT_ANEN 7
`define P1BC_ALT_PWRDN 11
`define P1BC_ALT_ANRESTART 13
`define P1BC_ALT_FULLDUP 5
`define P1BC_ALT_FORCEMDIX 9
`define P1BC_ALT_DISMDIX 10
`define P1BC_ALT_DISFEF 12
`define P1BC_ALT_DISTX 14
`define P1BC_ALT_DISLED 15
`define P1BC_RESET_CTRL 16'h1020
`define P1BC_WRITE_MASK 16'h7B3F
`define P1BC_RESP_OKAY 2'b00
`define P1BC_RESP_SLVERR 2'b10
`endif

// ===== rtl/p1bc_pkg.sv
// types for the port 1 basic control bank
// assumes the constants header is included alongside
package p1bc_pkg;
  typedef enum logic {P1BC_SPEED_10, P1BC_SPEED_100} p1bc_speed_t;
endpackage : p1bc_pkg

// ===== rtl/p1bc_port1_phy_basic_control.sv
// port 1 transceiver basic control register with an axi4-lite slave
// assumes synchronous inputs, one clock at 20 MHz, async active-low reset
`timescale 1ns/1ps
`include "p1bc_defines.svh"
module p1bc_port1_phy_basic_control import p1bc_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic remoteLoopback,
  output p1bc_speed_t portSpeed,
  output logic fullDuplex,
  output logic powerDown,
  output logic negotiationRestart,
  output logic crossoverAlgorithmSelect,
  output logic autoCrossoverOff,
  output logic forceCrossed,
  output logic farEndFaultDetectOff,
  output logic transmitOff,
  output logic ledOff
);
  logic rstSync1Q, rstSync2Q;
  logic [15:0] ctrlQ, ctrlD;
  logic awHeldQ, wHeldQ;
  logic [11:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic bvalidQ, rvalidQ;
  logic [1:0] brespQ, rrespQ;
  logic [31:0] rdataQ;
  logic restartQ;

  // reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstSync1Q <= 1'b0;
      rstSync2Q <= 1'b0;
    end else begin
      rstSync1Q <= 1'b1;
      rstSync2Q <= rstSync1Q;
    end
  end

  // map basic-view bits to alternate-view positions
  function automatic logic [15:0] toAlt(input logic [15:0] b);
    logic [15:0] a;
    a = 16'h0000;
    a[`P1BC_ALT_LOOPBACK] = b[`P1BC_BIT_LOOPBACK];
    a[`P1BC_ALT_FORCE100] = b[`P1BC_BIT_FORCE100];
    a[`P1BC_ALT_ANEN] = b[`P1BC_BIT_ANEN];
    a[`P1BC_ALT_PWRDN] = b[`P1BC_BIT_PWRDN];
    a[`P1BC_ALT_ANRESTART] = b[`P1BC_BIT_ANRESTART];
    a[`P1BC_ALT_FULLDUP] = b[`P1BC_BIT_FULLDUP];
    a[`P1BC_ALT_FORCEMDIX] = b[`P1BC_BIT_FORCEMDIX];
    a[`P1BC_ALT_DISMDIX] = b[`P1BC_BIT_DISMDIX];
    a[`P1BC_ALT_DISFEF] = b[`P1BC_BIT_DISFEF];
    a[`P1BC_ALT_DISTX] = b[`P1BC_BIT_DISTX];
    a[`P1BC_ALT_DISLED] = b[`P1BC_BIT_DISLED];
    return a;
  endfunction : toAlt

  // inverse mapping, alternate view back to basic layout
  function automatic logic [15:0] fromAlt(input logic [15:0] a);
    logic [15:0] b;
    b = 16'h0000;
    b[`P1BC_BIT_LOOPBACK] = a[`P1BC_ALT_LOOPBACK];
    b[`P1BC_BIT_FORCE100] = a[`P1BC_ALT_FORCE100];
    b[`P1BC_BIT_ANEN] = a[`P1BC_ALT_ANEN];
    b[`P1BC_BIT_PWRDN] = a[`P1BC_ALT_PWRDN];
    b[`P1BC_BIT_ANRESTART] = a[`P1BC_ALT_ANRESTART];
    b[`P1BC_BIT_FULLDUP] = a[`P1BC_ALT_FULLDUP];
    b[`P1BC_BIT_FORCEMDIX] = a[`P1BC_ALT_FORCEMDIX];
    b[`P1BC_BIT_DISMDIX] = a[`P1BC_ALT_DISMDIX];
    b[`P1BC_BIT_DISFEF] = a[`P1BC_ALT_DISFEF];
    b[`P1BC_BIT_DISTX] = a[`P1BC_ALT_DISTX];
    b[`P1BC_BIT_DISLED] = a[`P1BC_ALT_DISLED];
    return b;
  endfunction : fromAlt

  // write channel decode; address and data may come in either order
  wire writeFire = awHeldQ && wHeldQ && !bvalidQ;
  wire hitBasic = awAddrQ[11:2] == 10'(`P1BC_OFS_BASIC >> 2);
  wire hitAlt = awAddrQ[11:2] == 10'(`P1BC_OFS_ALT >> 2);
  wire [15:0] wrBasic = hitAlt ? fromAlt(wDataQ[15:0]) : wDataQ[15:0];
  wire [15:0] laneMask = {{8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
  wire [15:0] altLaneMask = hitAlt ? fromAlt(laneMask) : laneMask;
  wire [15:0] wrMask = `P1BC_WRITE_MASK & altLaneMask;
  assign awready = !awHeldQ;
  assign wready = !wHeldQ;
  assign bvalid = bvalidQ;
  assign bresp = brespQ;

  assign ctrlD = (writeFire && (hitBasic || hitAlt)) ?
    ((ctrlQ & ~wrMask) | (wrBasic & wrMask)) : ctrlQ;

  // write address/data holding and response
  always_ff @(posedge clock or negedge rstSync2Q) begin
    if (!rstSync2Q) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 12'h000;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      bvalidQ <= 1'b0;
      brespQ <= `P1BC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (writeFire) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        bvalidQ <= 1'b1;
        brespQ <= (hitBasic || hitAlt) ? `P1BC_RESP_OKAY : `P1BC_RESP_SLVERR;
      end else if (bvalidQ && bready) begin
        bvalidQ <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstSync2Q) begin
    if (!rstSync2Q) begin
      ctrlQ <= `P1BC_RESET_CTRL;
    end else begin
      ctrlQ <= ctrlD;
    end
  end

  // restart pulse when the restart bit goes from zero to one
  always_ff @(posedge clock or negedge rstSync2Q) begin
    if (!rstSync2Q) begin
      restartQ <= 1'b0;
    end else begin
      restartQ <= ctrlD[`P1BC_BIT_ANRESTART] && !ctrlQ[`P1BC_BIT_ANRESTART];
    end
  end

  // read channel: one read at a time, unmapped answers slverr
  wire rdBasic = araddr[11:2] == 10'(`P1BC_OFS_BASIC >> 2);
  wire rdAlt = araddr[11:2] == 10'(`P1BC_OFS_ALT >> 2);
  assign arready = !rvalidQ;
  assign rvalid = rvalidQ;
  assign rdata = rdataQ;
  assign rresp = rrespQ;
  always_ff @(posedge clock or negedge rstSync2Q) begin
    if (!rstSync2Q) begin
      rvalidQ <= 1'b0;
      rdataQ <= 32'h0000_0000;
      rrespQ <= `P1BC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalidQ <= 1'b1;
      rdataQ <= {16'h0000, rdAlt ? toAlt(ctrlQ) : (rdBasic ? ctrlQ : 16'h0000)};
      rrespQ <= (rdBasic || rdAlt) ? `P1BC_RESP_OKAY : `P1BC_RESP_SLVERR;
    end else if (rvalidQ && rready) begin
      rvalidQ <= 1'b0;
    end
  end

  // loopback control to the port 1 medium layers
  // turnaround stays below the switch fabric
  assign remoteLoopback = ctrlQ[`P1BC_BIT_LOOPBACK];
  assign portSpeed = ctrlQ[`P1BC_BIT_FORCE100] ? P1BC_SPEED_100 : P1BC_SPEED_10;
  // forced duplex, negotiation never succeeds here
  assign fullDuplex = ctrlQ[`P1BC_BIT_FULLDUP];
  // restart request, no effect on port 1
  assign negotiationRestart = restartQ;
  assign crossoverAlgorithmSelect = ctrlQ[`P1BC_BIT_XALG];
  assign autoCrossoverOff = ctrlQ[`P1BC_BIT_DISMDIX];
  assign forceCrossed = ctrlQ[`P1BC_BIT_FORCEMDIX];
  assign farEndFaultDetectOff = ctrlQ[`P1BC_BIT_DISFEF];
  assign transmitOff = ctrlQ[`P1BC_BIT_DISTX];
  assign ledOff = ctrlQ[`P1BC_BIT_DISLED];
  assign powerDown = ctrlQ[`P1BC_BIT_PWRDN];
endmodule : p1bc_port1_phy_basic_control

// ===== verification/p1bc_port1_phy_basic_control_bench.sv
// self-checking bench for the basic control bank
// assumes the design and its checker are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module p1bc_port1_phy_basic_control_bench import p1bc_pkg::*; ;
  logic clock = 0, rstn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, remoteLoopback, fullDuplex, powerDown;
  logic negotiationRestart, crossoverAlgorithmSelect, autoCrossoverOff, forceCrossed;
  logic farEndFaultDetectOff, transmitOff, ledOff;
  logic [1:0] bresp, rresp;
  p1bc_speed_t portSpeed;
  int failures = 0, n_compared = 0, pulses = 0;
  wire [9:0] outs = {remoteLoopback, portSpeed, fullDuplex, powerDown, crossoverAlgorithmSelect,
    forceCrossed, autoCrossoverOff, farEndFaultDetectOff, transmitOff, ledOff};
  // clock and restart pulse count, sampled mid-cycle to stay clear of the edge
  always #25 clock = ~clock;
  always @(negedge clock) if (negotiationRestart === 1'b1) pulses++;
  p1bc_port1_phy_basic_control DUT (.*);
  // one bus transfer; readies sampled on the falling edge, acted on at the next rise
  task automatic bus(input bit w, input logic [11:0] a, input logic [15:0] d,
      input logic [1:0] er);
    bit ta, tw, tr, td;
    int n;
    logic [31:0] g;
    logic [1:0] r;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    araddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    do begin
      @(negedge clock);
      ta = awready;
      tw = wready;
      tr = arready;
      td = w ? bvalid : rvalid;
      g = rdata;
      r = w ? bresp : rresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      n++;
    end while (!td && n < 20);
    `CHK("answer", 1'b1, td)
    `CHK("resp", er, r)
    if (!w) `CHK("rdata", {16'h0000, d}, g)
  endtask : bus
  task t_reset;
    bus(0, 12'h000, 16'h1020, 2'b00);
    `CHK("outs", 10'h020, outs)
  endtask : t_reset
  task t_fields;
    bus(1, 12'h000, 16'hFFFF, 2'b00);
    bus(0, 12'h000, 16'h7B3F, 2'b00);
    `CHK("outs", 10'h3FF, outs)
    bus(1, 12'h000, 16'h0000, 2'b00);
    `CHK("outs", 10'h000, outs)
  endtask : t_fields
  task t_alt;
    bus(1, 12'h004, 16'h0140, 2'b00);
    bus(0, 12'h000, 16'h6000, 2'b00);
    `CHK("outs", 10'h300, outs)
    bus(1, 12'h000, 16'h0101, 2'b00);
    bus(0, 12'h004, 16'h8020, 2'b00);
  endtask : t_alt
  task t_bad;
    bus(1, 12'h010, 16'hFFFF, 2'b10);
    bus(0, 12'h010, 16'h0000, 2'b10);
    bus(0, 12'h000, 16'h0101, 2'b00);
  endtask : t_bad
  task t_restart;
    bus(1, 12'h000, 16'h0200, 2'b00);
    repeat (2) @(posedge clock);
    `CHK("pulse", 2, pulses)
    bus(1, 12'h000, 16'h0200, 2'b00);
    repeat (2) @(posedge clock);
    `CHK("pulse", 2, pulses)
  endtask : t_restart
  task complete_run;
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // main sequence after the reset hold
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset;
    t_fields;
    t_alt;
    t_bad;
    t_restart;
    complete_run;
  end
  // hang guard, far beyond the sixty or so cycles the tests take
  initial begin
    #100000;
    failures++;
    complete_run;
  end
endmodule : p1bc_port1_phy_basic_control_bench

// ===== verification/p1bc_properties.sv
// assertions on the basic control bank ports
// assumes bound onto the top module, full strobes on writes
`timescale 1ns/1ps
module p1bc_properties import p1bc_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic remoteLoopback,
  input wire p1bc_speed_t portSpeed,
  input wire logic fullDuplex,
  input wire logic powerDown,
  input wire logic negotiationRestart,
  input wire logic forceCrossed
);
  logic [11:0] wa;
  logic [15:0] wd;
  // last accepted write, kept since the bus lets go before the answer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wa <= 12'h000;
      wd <= 16'h0000;
    end else begin
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata[15:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // a write to the basic view has just landed
  sequence upd;
    $rose(bvalid) && wa == 12'h000;
  endsequence
  chk_loop_follow:
    assert property (upd |-> remoteLoopback == wd[14]) else $error("loopback bad");
  chk_speed_follow:
    assert property (upd |-> portSpeed == p1bc_speed_t'(wd[13])) else $error("speed bad");
  chk_duplex_follow:
    assert property (upd |-> fullDuplex == wd[8]) else $error("duplex bad");
  chk_power_follow:
    assert property (upd |-> powerDown == wd[11]) else $error("power bad");
  chk_cross_follow:
    assert property (upd |-> forceCrossed == wd[4]) else $error("crossover bad");
  chk_restart_pulse:
    assert property (negotiationRestart |=> !negotiationRestart) else $error("pulse long");
  chk_bad_addr:
    assert property ($rose(bvalid) && wa > 12'h004 |-> bresp == 2'b10) else $error("no slverr");
  chk_upper_zero:
    assert property (rvalid |-> rdata[31:16] == 16'h0000) else $error("upper bits set");
  cover property (upd);
  cover property ($rose(bvalid) && bresp == 2'b10);
  cover property (negotiationRestart);
endmodule : p1bc_properties
bind p1bc_port1_phy_basic_control p1bc_properties chk (.*);
